// *** src/ldmac_cfg.svh ***
// Offsets, field positions, reset values and decode constants of the local DMA controller
`ifndef LDMAC_CFG_SVH
`define LDMAC_CFG_SVH
`define LDMAC_CFG_STATE_ADDR 32'h01820000
`define LDMAC_CFG_SKIP_ADDR 32'h01820004
`define LDMAC_CFG_SRC_ADDR 32'h01820008
`define LDMAC_CFG_DST_ADDR 32'h0182000c
`define LDMAC_CFG_BLOCKS_ADDR 32'h01820010
`define LDMAC_MEM_STATE_ADDR 32'h01820100
`define LDMAC_MEM_SRC_ADDR 32'h01820108
`define LDMAC_MEM_DST_ADDR 32'h0182010c
`define LDMAC_MEM_LENGTH_ADDR 32'h01820110
`define LDMAC_STAT_ACTIVE_BIT 0
`define LDMAC_STAT_PENDING_BIT 1
`define LDMAC_IRQ_ENABLE_BIT 28
`define LDMAC_FILL_BIT 16
`define LDMAC_PRI_LSB 29
`define LDMAC_LENGTH_MSB 15
`define LDMAC_BLOCKS_MSB 3
`define LDMAC_CFG_ALIGN_LSB 5
`define LDMAC_SKIP_RESET 32'h00000000
`define LDMAC_WORDS_PER_BLOCK 32
`endif

// *** src/ldmac_pkg.sv ***
// Types shared by the local DMA controller modules
package ldmac_pkg;
   typedef enum logic [1:0] {LDMAC_IDLE, LDMAC_READ, LDMAC_WRITE} ldmac_phase_t;
   typedef struct packed
   {
      logic [31:0] src;
      logic [31:0] dst;
      logic [31:0] ctl;
      logic [31:0] skip;
   } ldmac_job_t;
endpackage

// *** src/ldmac_mem_if.sv ***
// Memory request interface between a channel engine and its local memory
`timescale 1ns/1ns
`default_nettype none
interface ldmac_mem_if;
   logic req;
   logic we;
   logic [31:0] addr;
   logic [31:0] wdata;
   logic [3:0] be;
   logic ack;
   logic [31:0] rdata;
   modport engine (output req, output we, output addr, output wdata, output be, input ack, input rdata);
   modport memory (input req, input we, input addr, input wdata, input be, output ack, output rdata);
endinterface
`default_nettype wire

// *** src/ldmac_channel.sv ***
// One channel: active and pending slots plus a read-then-write copy engine
`timescale 1ns/1ns
`default_nettype none
`include "ldmac_cfg.svh"
module ldmac_channel #(
   parameter bit CFG_KIND = 1'b0
)(
   input wire logic i_clk_sys,              // Core clock
   input wire logic i_rst,                  // Sync reset
   input wire logic i_submit,               // Count register written
   input var ldmac_pkg::ldmac_job_t i_job,  // Parameters at submit
   input wire logic i_abort,                // Drop active job
   ldmac_mem_if.engine mem,                 // Memory side
   output logic o_active,                   // Active flag
   output logic o_pending,                  // Pending flag
   output logic o_done,                     // Completion pulse
   output logic o_done_irq_en               // Irq enable of finished job
);
   ldmac_pkg::ldmac_job_t act_job;
   ldmac_pkg::ldmac_job_t transfer_pending_flag_job;
   ldmac_pkg::ldmac_phase_t phase;
   logic [31:0] src_ptr;
   logic [31:0] dst_ptr;
   logic [31:0] data;
   logic [4:0] word_idx;
   logic [3:0] blocks_left;
   logic [16:0] bytes_left;
   logic fill;
   logic last_item;
   logic word_skipped;
   logic start_next;
   logic finish;

   assign fill = act_job.ctl[`LDMAC_FILL_BIT] && !CFG_KIND;
   assign word_skipped = CFG_KIND && act_job.skip[word_idx];
   assign last_item = CFG_KIND ? (word_idx == 5'h1f && blocks_left == 4'h0)
                               : (bytes_left <= 17'h00004);
   assign start_next = (phase == ldmac_pkg::LDMAC_IDLE) && o_pending && !o_active;
   assign finish = o_active && ((phase == ldmac_pkg::LDMAC_WRITE && mem.ack && last_item)
                   || (phase == ldmac_pkg::LDMAC_READ && word_skipped && last_item));

   // Slot bookkeeping; submission happens only on count write
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         o_active <= 1'b0;
         o_pending <= 1'b0;
      end
      else
      begin
         if (finish || i_abort)
            o_active <= 1'b0;
         else if (start_next)
            o_active <= 1'b1;
         if (i_submit && (o_active || o_pending) && !start_next)
            o_pending <= 1'b1;
         else if (i_submit && !o_active)
            o_pending <= 1'b1;
         else if (start_next)
            o_pending <= 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         transfer_pending_flag_job <= '0;
      else if (i_submit)
         transfer_pending_flag_job <= i_job;
   end

   // Copy engine: one word per read-write pair, read skipped when fill is set, linear increment
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         phase <= ldmac_pkg::LDMAC_IDLE;
         act_job <= '0;
         src_ptr <= 32'h00000000;
         dst_ptr <= 32'h00000000;
         data <= 32'h00000000;
         word_idx <= 5'h00;
         blocks_left <= 4'h0;
         bytes_left <= 17'h00000;
      end
      else
      begin
         case (phase)
            ldmac_pkg::LDMAC_IDLE:
            begin
               if (start_next)
               begin
                  act_job <= transfer_pending_flag_job;
                  src_ptr <= transfer_pending_flag_job.src;
                  dst_ptr <= transfer_pending_flag_job.dst;
                  data <= transfer_pending_flag_job.src;
                  word_idx <= 5'h00;
                  blocks_left <= transfer_pending_flag_job.ctl[`LDMAC_BLOCKS_MSB:0];
                  bytes_left <= {1'b0, transfer_pending_flag_job.ctl[`LDMAC_LENGTH_MSB:0]};
                  phase <= ldmac_pkg::LDMAC_READ;
               end
            end
            ldmac_pkg::LDMAC_READ:
            begin
               if (i_abort)
                  phase <= ldmac_pkg::LDMAC_IDLE;
               else if (word_skipped)
               begin
                  src_ptr <= src_ptr + 32'h00000004;
                  dst_ptr <= dst_ptr + 32'h00000004;
                  word_idx <= word_idx + 5'h01;
                  if (word_idx == 5'h1f)
                     blocks_left <= blocks_left - 4'h1;
                  if (last_item)
                     phase <= ldmac_pkg::LDMAC_IDLE;
               end
               else if (fill)
                  phase <= ldmac_pkg::LDMAC_WRITE;
               else if (mem.ack)
               begin
                  data <= mem.rdata;
                  phase <= ldmac_pkg::LDMAC_WRITE;
               end
            end
            ldmac_pkg::LDMAC_WRITE:
            begin
               if (i_abort)
                  phase <= ldmac_pkg::LDMAC_IDLE;
               else if (mem.ack)
               begin
                  src_ptr <= src_ptr + 32'h00000004;
                  dst_ptr <= dst_ptr + 32'h00000004;
                  word_idx <= word_idx + 5'h01;
                  bytes_left <= bytes_left - 17'h00004;
                  if (word_idx == 5'h1f)
                     blocks_left <= blocks_left - 4'h1;
                  phase <= last_item ? ldmac_pkg::LDMAC_IDLE : ldmac_pkg::LDMAC_READ;
               end
            end
            default:
               phase <= ldmac_pkg::LDMAC_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         o_done <= 1'b0;
         o_done_irq_en <= 1'b0;
      end
      else
      begin
         o_done <= finish;
         o_done_irq_en <= act_job.ctl[`LDMAC_IRQ_ENABLE_BIT];
      end
   end

   // Skipped words issue no access; last partial word uses byte enables
   always_comb
   begin
      mem.req = o_active && !i_abort && !word_skipped && ((phase == ldmac_pkg::LDMAC_READ && !fill)
                || phase == ldmac_pkg::LDMAC_WRITE);
      mem.we = (phase == ldmac_pkg::LDMAC_WRITE);
      mem.addr = mem.we ? dst_ptr : src_ptr;
      mem.wdata = data;
      if (!CFG_KIND && bytes_left < 17'h00004)
         mem.be = (4'h1 << bytes_left[1:0]) - 4'h1;
      else
         mem.be = 4'hf;
   end
endmodule
`default_nettype wire

// *** src/ldmac_top.sv ***
// Two-channel local DMA controller: register decode, exception check, channel engines
`timescale 1ns/1ns
`default_nettype none
`include "ldmac_cfg.svh"
module ldmac_top #(
   parameter logic [31:0] CFG_SPACE_BASE = 32'h01800000, // External config space base
   parameter logic [31:0] CFG_SPACE_MASK = 32'hff800000  // External config space mask
)(
   input wire logic i_clk_sys,        // Core clock, 25 MHz
   input wire logic i_rst,            // Sync reset, active high
   input wire logic i_reg_sel,        // Register access strobe
   input wire logic i_reg_we,         // Write when high
   input wire logic [31:0] i_reg_addr, // Byte address
   input wire logic [31:0] i_reg_wdata, // Write data
   output logic [31:0] o_reg_rdata,   // Read data, registered
   output logic o_reg_ack,            // Access done pulse
   output logic o_m0_req,             // Config channel request
   output logic o_m0_we,              // Config channel write
   output logic [31:0] o_m0_addr,     // Config channel address
   output logic [31:0] o_m0_wdata,    // Config channel write data
   output logic [3:0] o_m0_be,        // Config channel byte enables
   input wire logic i_m0_ack,         // Config channel done
   input wire logic [31:0] i_m0_rdata, // Config channel read data
   output logic o_m1_req,             // Memory channel request
   output logic o_m1_we,              // Memory channel write
   output logic [31:0] o_m1_addr,     // Memory channel address
   output logic [31:0] o_m1_wdata,    // Memory channel write data
   output logic [3:0] o_m1_be,        // Memory channel byte enables
   input wire logic i_m1_ack,         // Memory channel done
   input wire logic [31:0] i_m1_rdata, // Memory channel read data
   output logic o_cfg_channel_done_irq, // Config channel completion pulse
   output logic o_mem_channel_done_irq, // Memory channel completion pulse
   output logic o_cfg_channel_exception, // Both-ends-in-config exception pulse
   output logic [2:0] o_mem_priority  // Arbitration priority of memory channel
);
   logic [31:0] cfg_channel_word_skip;
   logic [31:0] cfg_channel_src_ptr;
   logic [31:0] cfg_channel_dst_ptr;
   logic [31:0] cfg_channel_blocks;
   logic [31:0] mem_channel_src_ptr;
   logic [31:0] mem_channel_dst_ptr;
   logic [31:0] mem_channel_length;
   logic wr;
   logic cfg_submit;
   logic mem_submit;
   logic cfg_both_ext;
   logic cfg_active;
   logic cfg_pending;
   logic cfg_done;
   logic cfg_irq_en;
   logic mem_active;
   logic mem_pending;
   logic mem_done;
   logic mem_irq_en;
   logic cfg_abort;
   ldmac_pkg::ldmac_job_t cfg_job;
   ldmac_pkg::ldmac_job_t mem_job;

   ldmac_mem_if m0 ();
   ldmac_mem_if m1 ();

   function automatic logic in_cfg_space(input logic [31:0] a);
      in_cfg_space = (a & CFG_SPACE_MASK) == CFG_SPACE_BASE;
   endfunction

   function automatic logic [31:0] status_word(input logic transfer_pending_flag, input logic act);
      status_word = 32'h00000000;
      status_word[`LDMAC_STAT_PENDING_BIT] = transfer_pending_flag;
      status_word[`LDMAC_STAT_ACTIVE_BIT] = act;
   endfunction

   // Whole-register write on any width: low address bits ignored
   assign wr = i_reg_sel && i_reg_we;
   assign cfg_submit = wr && i_reg_addr[31:2] == `LDMAC_CFG_BLOCKS_ADDR >> 2;
   assign mem_submit = wr && i_reg_addr[31:2] == `LDMAC_MEM_LENGTH_ADDR >> 2;
   assign cfg_both_ext = in_cfg_space(cfg_channel_src_ptr) && in_cfg_space(cfg_channel_dst_ptr);
   assign cfg_abort = 1'b0;

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         cfg_channel_word_skip <= `LDMAC_SKIP_RESET;
         cfg_channel_src_ptr <= 32'h00000000;
         cfg_channel_dst_ptr <= 32'h00000000;
         cfg_channel_blocks <= 32'h00000000;
         mem_channel_src_ptr <= 32'h00000000;
         mem_channel_dst_ptr <= 32'h00000000;
         mem_channel_length <= 32'h00000000;
      end
      else if (wr)
      begin
         case ({i_reg_addr[31:2], 2'b00})
            `LDMAC_CFG_SKIP_ADDR: cfg_channel_word_skip <= i_reg_wdata;
            `LDMAC_CFG_SRC_ADDR:
               cfg_channel_src_ptr <= {i_reg_wdata[31:`LDMAC_CFG_ALIGN_LSB], 5'h00};
            `LDMAC_CFG_DST_ADDR:
               cfg_channel_dst_ptr <= {i_reg_wdata[31:`LDMAC_CFG_ALIGN_LSB], 5'h00};
            `LDMAC_CFG_BLOCKS_ADDR:
               cfg_channel_blocks <= {3'h0, i_reg_wdata[`LDMAC_IRQ_ENABLE_BIT], 24'h000000,
                                      i_reg_wdata[`LDMAC_BLOCKS_MSB:0]};
            `LDMAC_MEM_SRC_ADDR: mem_channel_src_ptr <= i_reg_wdata;
            `LDMAC_MEM_DST_ADDR: mem_channel_dst_ptr <= i_reg_wdata;
            `LDMAC_MEM_LENGTH_ADDR: mem_channel_length <= i_reg_wdata;
            default: ;
         endcase
      end
   end

   // Registered read data, unmapped reads return zero
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         o_reg_rdata <= 32'h00000000;
         o_reg_ack <= 1'b0;
      end
      else
      begin
         o_reg_ack <= i_reg_sel;
         case ({i_reg_addr[31:2], 2'b00})
            `LDMAC_CFG_STATE_ADDR: o_reg_rdata <= status_word(cfg_pending, cfg_active);
            `LDMAC_CFG_SKIP_ADDR: o_reg_rdata <= cfg_channel_word_skip;
            `LDMAC_CFG_SRC_ADDR: o_reg_rdata <= cfg_channel_src_ptr;
            `LDMAC_CFG_DST_ADDR: o_reg_rdata <= cfg_channel_dst_ptr;
            `LDMAC_CFG_BLOCKS_ADDR: o_reg_rdata <= cfg_channel_blocks;
            `LDMAC_MEM_STATE_ADDR: o_reg_rdata <= status_word(mem_pending, mem_active);
            `LDMAC_MEM_SRC_ADDR: o_reg_rdata <= mem_channel_src_ptr;
            `LDMAC_MEM_DST_ADDR: o_reg_rdata <= mem_channel_dst_ptr;
            `LDMAC_MEM_LENGTH_ADDR: o_reg_rdata <= mem_channel_length;
            default: o_reg_rdata <= 32'h00000000;
         endcase
      end
   end

   // Jobs formed with the data being written on the count access
   always_comb
   begin
      cfg_job.src = cfg_channel_src_ptr;
      cfg_job.dst = cfg_channel_dst_ptr;
      cfg_job.skip = cfg_channel_word_skip;
      cfg_job.ctl = i_reg_wdata;
      mem_job.src = mem_channel_src_ptr;
      mem_job.dst = mem_channel_dst_ptr;
      mem_job.skip = 32'h00000000;
      mem_job.ctl = i_reg_wdata;
   end

   // Illegal config-to-config job is refused and flagged, memory channel untouched
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         o_cfg_channel_exception <= 1'b0;
      else
         o_cfg_channel_exception <= cfg_submit && cfg_both_ext;
   end

   ldmac_channel #(.CFG_KIND(1'b1)) u_cfg (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_submit(cfg_submit && !cfg_both_ext),
      .i_job(cfg_job),
      .i_abort(cfg_abort),
      .mem(m0.engine),
      .o_active(cfg_active),
      .o_pending(cfg_pending),
      .o_done(cfg_done),
      .o_done_irq_en(cfg_irq_en)
   );

   ldmac_channel #(.CFG_KIND(1'b0)) u_mem (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_submit(mem_submit),
      .i_job(mem_job),
      .i_abort(1'b0),
      .mem(m1.engine),
      .o_active(mem_active),
      .o_pending(mem_pending),
      .o_done(mem_done),
      .o_done_irq_en(mem_irq_en)
   );

   assign o_m0_req = m0.req;
   assign o_m0_we = m0.we;
   assign o_m0_addr = m0.addr;
   assign o_m0_wdata = m0.wdata;
   assign o_m0_be = m0.be;
   assign m0.ack = i_m0_ack;
   assign m0.rdata = i_m0_rdata;
   assign o_m1_req = m1.req;
   assign o_m1_we = m1.we;
   assign o_m1_addr = m1.addr;
   assign o_m1_wdata = m1.wdata;
   assign o_m1_be = m1.be;
   assign m1.ack = i_m1_ack;
   assign m1.rdata = i_m1_rdata;

   assign o_cfg_channel_done_irq = cfg_done && cfg_irq_en;
   assign o_mem_channel_done_irq = mem_done && mem_irq_en;
   assign o_mem_priority = mem_channel_length[`LDMAC_PRI_LSB +: 3];
endmodule
`default_nettype wire

// *** dv/ldmac_top_checker.sv ***
// Concurrent checks on the local DMA controller top ports
`timescale 1ns/1ns
`default_nettype none
`include "ldmac_cfg.svh"
module ldmac_top_checker (
   input wire logic i_clk_sys, // Core clock
   input wire logic i_rst, // Sync reset
   input wire logic i_reg_sel, // Access strobe
   input wire logic i_reg_we, // Write
   input wire logic [31:0] i_reg_addr, // Address
   input wire logic [31:0] o_reg_rdata, // Read data
   input wire logic o_reg_ack, // Access done
   input wire logic o_m0_req, // Cfg request
   input wire logic [31:0] o_m0_addr, // Cfg address
   input wire logic i_m0_ack, // Cfg done
   input wire logic o_m1_req, // Mem request
   input wire logic o_m1_we, // Mem write
   input wire logic [31:0] o_m1_addr, // Mem address
   input wire logic i_m1_ack, // Mem done
   input wire logic o_mem_channel_done_irq, // Mem done pulse
   input wire logic o_cfg_channel_exception // Exception pulse
);
   default clocking @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);
   sequence s_stat_read;
      i_reg_sel && !i_reg_we && (i_reg_addr == `LDMAC_MEM_STATE_ADDR || i_reg_addr == `LDMAC_CFG_STATE_ADDR);
   endsequence
   sequence s_m1_wait;
      o_m1_req && !i_m1_ack;
   endsequence
   sequence s_m0_wait;
      o_m0_req && !i_m0_ack;
   endsequence
   chk_ack_follows_sel: assert property (i_reg_sel |=> o_reg_ack)
      else $error("register access got no ack");
   chk_ack_has_cause: assert property (o_reg_ack |-> $past(i_reg_sel))
      else $error("ack without access");
   chk_status_upper_zero: assert property (s_stat_read |=> o_reg_rdata[31:2] == 30'h0)
      else $error("status upper bits not zero");
   chk_m1_req_held: assert property (s_m1_wait |=> o_m1_req && $stable(o_m1_addr) && $stable(o_m1_we))
      else $error("memory channel request dropped");
   chk_m0_req_held: assert property (s_m0_wait |=> o_m0_req && $stable(o_m0_addr))
      else $error("config channel request dropped");
   chk_done_after_write: assert property (o_mem_channel_done_irq |-> $past(o_m1_req && o_m1_we && i_m1_ack))
      else $error("done without final write");
   chk_done_one_cycle: assert property (o_mem_channel_done_irq |=> !o_mem_channel_done_irq)
      else $error("done pulse too long");
   chk_exc_cause: assert property (o_cfg_channel_exception |-> $past(i_reg_sel && i_reg_we
      && i_reg_addr == `LDMAC_CFG_BLOCKS_ADDR))
      else $error("exception without count write");
endmodule
bind ldmac_top ldmac_top_checker u_chk (.*);
`default_nettype wire

// *** dv/ldmac_mem_model.sv ***
// Local memory model answering channel requests after a set delay
`timescale 1ns/1ns
`default_nettype none
module ldmac_mem_model (
   input wire logic i_clk_sys, // Core clock
   input wire logic i_rst, // Sync reset
   input wire logic i_req, // Request
   input wire logic i_we, // Write
   input wire logic [31:0] i_addr, // Address
   input wire logic [1:0] i_delay, // Wait cycles
   output logic o_ack, // Done
   output logic [31:0] o_rdata // Read data
);
   logic [1:0] wait_cnt;
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         o_ack <= 1'b0;
         wait_cnt <= 2'h0;
         o_rdata <= 32'h0;
      end
      else if (i_req && !o_ack && wait_cnt >= i_delay)
      begin
         o_ack <= 1'b1;
         wait_cnt <= 2'h0;
         o_rdata <= i_we ? ~o_rdata : i_addr ^ 32'h5a5a5a5a;
      end
      else
      begin
         // Data not valid outside ack
         o_ack <= 1'b0;
         o_rdata <= ~o_rdata;
         wait_cnt <= (i_req && !o_ack) ? wait_cnt + 2'h1 : 2'h0;
      end
   end
endmodule
`default_nettype wire

// *** dv/local_memory_dma_two_channel_bench.sv ***
// Self-checking bench for the two-channel local DMA controller
`timescale 1ns/1ns
`default_nettype none
`include "ldmac_cfg.svh"
module local_memory_dma_two_channel_bench;
   logic i_clk_sys = 1'b0;
   logic i_rst = 1'b1;
   logic i_reg_sel = 1'b0;
   logic i_reg_we = 1'b0;
   logic [31:0] i_reg_addr = 32'h0;
   logic [31:0] i_reg_wdata = 32'h0;
   logic [31:0] o_reg_rdata, o_m0_addr, o_m0_wdata, i_m0_rdata, o_m1_addr, o_m1_wdata, i_m1_rdata;
   logic o_reg_ack, o_m0_req, o_m0_we, i_m0_ack, o_m1_req, o_m1_we, i_m1_ack;
   logic o_cfg_channel_done_irq, o_mem_channel_done_irq, o_cfg_channel_exception;
   logic [3:0] o_m0_be, o_m1_be;
   logic [2:0] o_mem_priority;
   logic [1:0] dly0 = 2'h0;
   logic [1:0] dly1 = 2'h0;
   logic [31:0] rnd = 32'h00003630;
   logic [31:0] mask = 32'h0;
   logic [31:0] r;
   logic [31:0] exp_wa[$];
   logic [31:0] exp_wd[$];
   logic [3:0] exp_be[$];
   int err_total = 0;
   int samples_checked = 0;
   int rd1 = 0, exp_rd1 = 0, rd0 = 0, wr0 = 0, irq0 = 0, irq1 = 0, exc = 0, req1 = 0;
   localparam logic [31:0] reg_map [9] = '{`LDMAC_CFG_STATE_ADDR, `LDMAC_CFG_SKIP_ADDR, `LDMAC_CFG_SRC_ADDR,
      `LDMAC_CFG_DST_ADDR, `LDMAC_CFG_BLOCKS_ADDR, `LDMAC_MEM_STATE_ADDR, `LDMAC_MEM_SRC_ADDR,
      `LDMAC_MEM_DST_ADDR, `LDMAC_MEM_LENGTH_ADDR};
   always #20 i_clk_sys = ~i_clk_sys;
   ldmac_top uut (.*);
   ldmac_mem_model mdl0 (.i_clk_sys, .i_rst, .i_req(o_m0_req), .i_we(o_m0_we), .i_addr(o_m0_addr),
      .i_delay(dly0), .o_ack(i_m0_ack), .o_rdata(i_m0_rdata));
   ldmac_mem_model mdl1 (.i_clk_sys, .i_rst, .i_req(o_m1_req), .i_we(o_m1_we), .i_addr(o_m1_addr),
      .i_delay(dly1), .o_ack(i_m1_ack), .o_rdata(i_m1_rdata));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      samples_checked++;
      if (seen !== want)
      begin
         err_total++;
         $display("Error at %0t: seen %h, expected %h", $time, seen, want);
      end
   endtask
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge i_clk_sys);
      i_reg_sel <= 1'b1;
      i_reg_we <= w;
      i_reg_addr <= a;
      i_reg_wdata <= d;
      @(posedge i_clk_sys);
      i_reg_sel <= 1'b0;
      #1;
      check({31'h0, o_reg_ack}, 32'h1);
      r = o_reg_rdata;
   endtask
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] want);
      acc(1'b0, a, 32'h0);
      check(r, want);
   endtask
   task automatic wait_idle(input logic [31:0] a);
      r = 32'h1;
      for (int i = 0; i < 500 && r !== 32'h0; i++)
         acc(1'b0, a, 32'h0);
      check(r, 32'h0);
   endtask
   task automatic mem_job(input logic [31:0] s, input logic [31:0] d, input logic [15:0] n, input logic fill,
      input logic irq);
      for (int k = 0; k < (n + 3) / 4; k++)
      begin
         exp_wa.push_back(d + 32'(4 * k));
         exp_wd.push_back(fill ? s : (s + 32'(4 * k)) ^ 32'h5a5a5a5a);
         exp_rd1 += fill ? 0 : 1;
         exp_be.push_back(k == (n + 3) / 4 - 1 && n[1:0] != 2'h0 ? 4'((5'h01 << n[1:0]) - 5'h01) : 4'hf);
      end
      acc(1'b1, `LDMAC_MEM_SRC_ADDR, s);
      acc(1'b1, `LDMAC_MEM_DST_ADDR, d);
      acc(1'b1, `LDMAC_MEM_LENGTH_ADDR, {3'h5, irq, 11'h0, fill, n});
   endtask
   // Completed accesses are seen at the falling edge before their ack edge
   always @(negedge i_clk_sys)
   begin
      req1 += int'(o_m1_req);
      if (o_m1_req && i_m1_ack && !o_m1_we)
         rd1++;
      if (o_m1_req && i_m1_ack && o_m1_we && exp_wa.size() == 0)
         check(o_m1_addr, 32'hffffffff);
      else if (o_m1_req && i_m1_ack && o_m1_we)
      begin
         check(o_m1_addr, exp_wa.pop_front());
         check(o_m1_wdata, exp_wd.pop_front());
         check({28'h0, o_m1_be}, {28'h0, exp_be.pop_front()});
      end
      if (o_m0_req && i_m0_ack && !o_m0_we)
         rd0++;
      if (o_m0_req && i_m0_ack && o_m0_we)
      begin
         wr0++;
         check({31'h0, mask[o_m0_addr[6:2]]}, 32'h0);
         check(o_m0_wdata, (o_m0_addr - 32'h01200000) ^ 32'h5a5a5a5a);
         check({28'h0, o_m0_be}, 32'h0000000f);
      end
      irq0 += int'(o_cfg_channel_done_irq);
      irq1 += int'(o_mem_channel_done_irq);
      exc += int'(o_cfg_channel_exception);
   end
   initial
   begin
      repeat (40000) @(posedge i_clk_sys);
      err_total++;
      finish_test();
   end
   initial
   begin
      int n;
      int ones;
      int w0;
      ones = 0;
      repeat (20) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      foreach (reg_map[i]) rd_chk(reg_map[i], 32'h0);
      rnd = lfsr(rnd);
      acc(1'b1, `LDMAC_CFG_SKIP_ADDR, rnd);
      rd_chk(`LDMAC_CFG_SKIP_ADDR, rnd);
      acc(1'b1, `LDMAC_CFG_SKIP_ADDR + 32'h2, 32'h0000f0f0);
      rd_chk(`LDMAC_CFG_SKIP_ADDR, 32'h0000f0f0);
      acc(1'b1, `LDMAC_CFG_SRC_ADDR, rnd);
      rd_chk(`LDMAC_CFG_SRC_ADDR, rnd & 32'hffffffe0);
      acc(1'b1, `LDMAC_MEM_STATE_ADDR, 32'hffffffff);
      rd_chk(`LDMAC_MEM_STATE_ADDR, 32'h0);
      acc(1'b1, 32'h01820104, rnd);
      rd_chk(32'h01820104, 32'h0);
      acc(1'b1, `LDMAC_MEM_SRC_ADDR, 32'h00800000);
      acc(1'b1, `LDMAC_MEM_DST_ADDR, 32'h00900000);
      repeat (8) @(posedge i_clk_sys);
      check(32'(req1), 32'h0);
      rd_chk(`LDMAC_MEM_DST_ADDR, 32'h00900000);
      for (int i = 0; i < 8; i++)
      begin
         rnd = lfsr(rnd);
         dly1 <= rnd[9:8];
         n = i < 2 ? 4 * i + 1 : int'(rnd[5:0]) + 1;
         mem_job(32'h00800000 | {rnd[23:16], 2'h0}, 32'h00a00000 | {rnd[31:24], 4'h0}, 16'(n), i[0], rnd[7]);
         ones += int'(rnd[7]);
         wait_idle(`LDMAC_MEM_STATE_ADDR);
      end
      dly1 <= 2'h3;
      mem_job(32'h00800000, 32'h00a00000, 16'd64, 1'b0, 1'b1);
      mem_job(32'h00800100, 32'h00a00100, 16'd8, 1'b1, 1'b0);
      rd_chk(`LDMAC_MEM_STATE_ADDR, 32'h3);
      wait_idle(`LDMAC_MEM_STATE_ADDR);
      check(32'(exp_wa.size()), 32'h0);
      check(32'(irq1), 32'(ones + 1));
      check(32'(rd1), 32'(exp_rd1));
      check({29'h0, o_mem_priority}, 32'h00000005);
      for (int i = 0; i < 3; i++)
      begin
         rnd = lfsr(rnd);
         dly0 <= i == 0 ? 2'h3 : rnd[1:0];
         mask = i == 0 ? 32'h4f4f4f4f : rnd & 32'h7fffffff;
         w0 = $countones(~mask) * (i + 1);
         wr0 = 0;
         rd0 = 0;
         irq0 = 0;
         acc(1'b1, `LDMAC_CFG_SKIP_ADDR, mask);
         acc(1'b1, `LDMAC_CFG_SRC_ADDR, 32'h00800000);
         acc(1'b1, `LDMAC_CFG_DST_ADDR, 32'h01a00000);
         acc(1'b1, `LDMAC_CFG_BLOCKS_ADDR, 32'hfffffff0 | i);
         wait_idle(`LDMAC_CFG_STATE_ADDR);
         check(32'(wr0), 32'(w0));
         check(32'(rd0), 32'(w0));
         check(32'(irq0), 32'h1);
         rd_chk(`LDMAC_CFG_BLOCKS_ADDR, 32'h10000000 | i);
      end
      exc = 0;
      wr0 = 0;
      acc(1'b1, `LDMAC_CFG_SRC_ADDR, 32'h01a00000);
      acc(1'b1, `LDMAC_CFG_DST_ADDR, 32'h01a00080);
      acc(1'b1, `LDMAC_CFG_BLOCKS_ADDR, 32'h0);
      repeat (4) @(posedge i_clk_sys);
      check(32'(exc), 32'h1);
      check(32'(wr0), 32'h0);
      rd_chk(`LDMAC_CFG_STATE_ADDR, 32'h0);
      finish_test();
   end
endmodule
`default_nettype wire
